/* core/oma_cfg.svh */
// Purpose: timing and configuration constants for the occupancy mode arbiter
// Assumes: 25 MHz reference clock
// Notes: derived counts are computed from the times and the clock rate
`ifndef OMA_CFG_SVH
`define OMA_CFG_SVH

// clock rate and period
`define OMA_CLK_HZ 25000000
`define OMA_CLK_NS 40
// one second of clock cycles, used as the prescaler period
`define OMA_SEC_CYC (`OMA_CLK_HZ)
// communication loss timeout
`define OMA_COMM_LOSS_MIN 15
`define OMA_COMM_LOSS_S (`OMA_COMM_LOSS_MIN * 60)
// timed override duration
`define OMA_BYPASS_MIN 120
`define OMA_BYPASS_S (`OMA_BYPASS_MIN * 60)
// capacity figures in percent
`define OMA_PCT_FULL 7'h64
`define OMA_PCT_OFF 7'h00
// widths of counters
`define OMA_PRESC_W 25
`define OMA_SEC_W 13

`endif

/* core/oma_pkg.sv */
// Purpose: types shared by the occupancy mode arbiter
// Assumes: constants come from oma_cfg.svh
// Notes: temperatures are unsigned fixed point, unit chosen by the system
package oma_pkg;

  // occupancy codes used by network inputs and the effective mode
  typedef enum logic [1:0] {
    OMA_OCC,
    OMA_UNOCC,
    OMA_BYPASS,
    OMA_STBY
  } oma_occ_t;

  // one communicated occupancy value with its validity
  typedef struct packed {
    logic valid;
    oma_occ_t val;
  } oma_occ_req_t;

  // communicated heating and cooling setpoints
  typedef struct packed {
    logic valid;
    logic [15:0] heat;
    logic [15:0] cool;
  } oma_sp_req_t;

  // unit configuration held outside this block
  typedef struct packed {
    logic [15:0] unocc_heat;
    logic [15:0] unocc_cool;
    logic [15:0] stby_heat;
    logic [15:0] stby_cool;
    logic [15:0] occ_heat;
    logic [15:0] occ_cool;
    logic [15:0] supp_delta;
    logic [6:0] econ_min;
    logic [6:0] econ_stby_min;
    logic bi_present;
    logic bi_norm_open;
    logic econ_enable;
    logic econ_possible;
    logic hydro_possible;
  } oma_cfg_t;

  // capacity commands to the end devices
  typedef struct packed {
    logic [6:0] econ_pct;
    logic [6:0] mech_cool_pct;
    logic supp_cool_on;
    logic hydro_heat_on;
    logic elec_heat_on;
  } oma_cap_t;

  // whole state of the arbiter
  typedef struct packed {
    logic bi_s1;
    logic bi_s2;
    logic on_s1;
    logic on_s2;
    logic on_s3;
    logic cancel_s1;
    logic cancel_s2;
    logic cancel_s3;
    logic [24:0] presc;
    logic [12:0] bypass_s;
    logic [12:0] comm_s;
    logic comm_lost;
    oma_occ_t mode;
    logic [15:0] heat_sp;
    logic [15:0] cool_sp;
    oma_cap_t cap;
  } oma_state_t;

endpackage

/* core/oma_arbiter.sv */
// Purpose: decide effective occupancy mode, setpoints and unoccupied capacity
// Assumes: network inputs arrive on ref_clk; buttons and binary input are pins
// Notes: occupied-mode cascade control lives outside; here only minimum positions
`include "oma_cfg.svh"
`timescale 1ns/10ps

module oma_arbiter #(
  parameter int unsigned SEC_CYC = `OMA_SEC_CYC,
  parameter int unsigned BYPASS_S = `OMA_BYPASS_S,
  parameter int unsigned COMM_LOSS_S = `OMA_COMM_LOSS_S
) (
  input wire logic ref_clk, // 25 MHz system clock
  input wire logic rst_n, // asynchronous reset
  input oma_pkg::oma_occ_req_t manual_occupancy_command_in, // manual command
  input oma_pkg::oma_occ_req_t scheduled_occupancy_in, // schedule
  input oma_pkg::oma_occ_req_t sensed_occupancy_in, // sensor
  input oma_pkg::oma_sp_req_t net_sp_in, // occupied setpoints from network
  input wire logic net_rx, // pulse on any received update
  input oma_pkg::oma_cfg_t cfg, // unit configuration
  input wire logic occ_bi_pin, // occupancy contact, high when closed
  input wire logic override_on_pin, // timed override on, high pressed
  input wire logic override_cancel_pin, // timed override cancel
  input wire logic cool_mode, // high in cooling, low in heating
  input wire logic [15:0] space_temp, // measured space temperature
  output oma_pkg::oma_occ_t eff_mode, // effective occupancy mode
  output logic [15:0] heat_sp, // active heating setpoint
  output logic [15:0] cool_sp, // active cooling setpoint
  output oma_pkg::oma_cap_t cap, // capacity commands
  output logic comm_lost, // network silent too long
  output logic bypass_timing // override timer running
);

  oma_pkg::oma_state_t s_q;
  oma_pkg::oma_state_t s_d;

  logic sec_tick;
  logic on_press;
  logic cancel_press;
  logic local_occ;
  logic sensor_occ;
  logic man_ok;
  logic sch_ok;
  oma_pkg::oma_occ_t base_mode;
  oma_pkg::oma_occ_t next_mode;
  logic too_warm;
  logic too_cold;
  logic far_warm;
  logic econ_primary;
  logic [12:0] bypass_nxt;

  // button edges come from the synchronised copies only
  assign on_press = s_q.on_s2 & ~s_q.on_s3;
  assign cancel_press = s_q.cancel_s2 & ~s_q.cancel_s3;
  assign sec_tick = (s_q.presc == 25'(SEC_CYC - 1));

  // contact sense depends on how the input is configured
  assign local_occ = cfg.bi_norm_open ? ~s_q.bi_s2 : s_q.bi_s2;

  // network occupancy inputs count only while the link is alive; net_sp_in is used regardless
  assign man_ok = manual_occupancy_command_in.valid & ~s_q.comm_lost;
  assign sch_ok = scheduled_occupancy_in.valid & ~s_q.comm_lost;

  // sensor source: network value first, then hardwired, else occupied
  always_comb begin
    if (sensed_occupancy_in.valid && !s_q.comm_lost) begin
      sensor_occ = (sensed_occupancy_in.val != oma_pkg::OMA_UNOCC);
    end else if (cfg.bi_present) begin
      sensor_occ = local_occ;
    end else begin
      sensor_occ = 1'b1;
    end
  end

  // arbitration of manual command, schedule and sensor
  always_comb begin
    base_mode = oma_pkg::OMA_OCC;
    if (man_ok) begin
      unique case (manual_occupancy_command_in.val)
        oma_pkg::OMA_OCC: base_mode = oma_pkg::OMA_OCC;
        oma_pkg::OMA_UNOCC: base_mode = oma_pkg::OMA_UNOCC;
        oma_pkg::OMA_STBY: base_mode = oma_pkg::OMA_STBY;
        oma_pkg::OMA_BYPASS: begin
          if (sch_ok) begin
            // a scheduled occupied period is already an occupied-type request
            if (scheduled_occupancy_in.val == oma_pkg::OMA_OCC) begin
              base_mode = oma_pkg::OMA_OCC;
            end else begin
              base_mode = oma_pkg::OMA_BYPASS;
            end
          end else begin
            base_mode = sensor_occ ? oma_pkg::OMA_OCC : oma_pkg::OMA_BYPASS;
          end
        end
      endcase
    end else if (sch_ok) begin
      unique case (scheduled_occupancy_in.val)
        oma_pkg::OMA_OCC: begin
          base_mode = sensor_occ ? oma_pkg::OMA_OCC : oma_pkg::OMA_STBY;
        end
        oma_pkg::OMA_UNOCC: base_mode = oma_pkg::OMA_UNOCC;
        oma_pkg::OMA_STBY: base_mode = oma_pkg::OMA_STBY;
        oma_pkg::OMA_BYPASS: base_mode = oma_pkg::OMA_BYPASS;
      endcase
    end else begin
      // stand-alone: the sensor can only pick occupied or unoccupied
      base_mode = sensor_occ ? oma_pkg::OMA_OCC : oma_pkg::OMA_UNOCC;
    end
  end

  // override timer: a press always reloads, even over a cancel
  // kept apart from the state copy so the mode logic reads no loop through s_d
  always_comb begin
    bypass_nxt = s_q.bypass_s;
    if (on_press) begin
      bypass_nxt = 13'(BYPASS_S);
    end else if (cancel_press) begin
      bypass_nxt = '0;
    end else if (sec_tick && s_q.bypass_s != 13'h0000) begin
      bypass_nxt = s_q.bypass_s - 13'h0001;
    end
  end

  // a running override lifts unoccupied into bypass
  always_comb begin
    next_mode = base_mode;
    if (base_mode == oma_pkg::OMA_UNOCC && bypass_nxt != 13'h0000) begin
      next_mode = oma_pkg::OMA_BYPASS;
    end
  end

  // unoccupied comparisons against the stored setpoints
  assign too_warm = space_temp > cfg.unocc_cool;
  assign too_cold = space_temp < cfg.unocc_heat;
  assign far_warm = {1'b0, space_temp} > ({1'b0, cfg.unocc_cool} + {1'b0, cfg.supp_delta});
  assign econ_primary = cfg.econ_enable & cfg.econ_possible;

  // next state: synchronisers, timers, mode and outputs
  always_comb begin
    s_d = s_q;
    s_d.bi_s1 = occ_bi_pin;
    s_d.bi_s2 = s_q.bi_s1;
    s_d.on_s1 = override_on_pin;
    s_d.on_s2 = s_q.on_s1;
    s_d.on_s3 = s_q.on_s2;
    s_d.cancel_s1 = override_cancel_pin;
    s_d.cancel_s2 = s_q.cancel_s1;
    s_d.cancel_s3 = s_q.cancel_s2;

    // one-second prescaler keeps the long timers narrow
    if (sec_tick) begin
      s_d.presc = '0;
    end else begin
      s_d.presc = s_q.presc + 25'h0000001;
    end

    // link watchdog: any update restarts it
    if (net_rx) begin
      s_d.comm_s = '0;
      s_d.comm_lost = 1'b0;
    end else if (sec_tick && !s_q.comm_lost) begin
      if (s_q.comm_s == 13'(COMM_LOSS_S - 1)) begin
        s_d.comm_lost = 1'b1;
      end else begin
        s_d.comm_s = s_q.comm_s + 13'h0001;
      end
    end

    s_d.bypass_s = bypass_nxt;

    s_d.mode = next_mode;

    // setpoints follow the mode that is taking effect
    unique case (next_mode)
      oma_pkg::OMA_UNOCC: begin
        s_d.heat_sp = cfg.unocc_heat;
        s_d.cool_sp = cfg.unocc_cool;
      end
      oma_pkg::OMA_STBY: begin
        s_d.heat_sp = cfg.stby_heat;
        s_d.cool_sp = cfg.stby_cool;
      end
      default: begin
        s_d.heat_sp = net_sp_in.valid ? net_sp_in.heat : cfg.occ_heat;
        s_d.cool_sp = net_sp_in.valid ? net_sp_in.cool : cfg.occ_cool;
      end
    endcase

    // capacity: on/off control only while unoccupied
    s_d.cap = '0;
    unique case (next_mode)
      oma_pkg::OMA_UNOCC: begin
        if (cool_mode && too_warm) begin
          if (econ_primary) begin
            s_d.cap.econ_pct = `OMA_PCT_FULL;
            s_d.cap.supp_cool_on = far_warm;
          end else begin
            s_d.cap.mech_cool_pct = `OMA_PCT_FULL;
            s_d.cap.supp_cool_on = far_warm;
          end
        end else if (!cool_mode && too_cold) begin
          s_d.cap.hydro_heat_on = cfg.hydro_possible;
          s_d.cap.elec_heat_on = ~cfg.hydro_possible;
        end else begin
          s_d.cap = '0;
        end
      end
      oma_pkg::OMA_STBY: begin
        // reduced ventilation while the room is vacant
        s_d.cap.econ_pct = cfg.econ_stby_min;
      end
      default: begin
        s_d.cap.econ_pct = cfg.econ_min;
      end
    endcase
  end

  // single state register; reset only loads constants
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // every output but bypass_timing, a decode of bypass_s, is a field of the state register
  assign eff_mode = s_q.mode;
  assign heat_sp = s_q.heat_sp;
  assign cool_sp = s_q.cool_sp;
  assign cap = s_q.cap;
  assign comm_lost = s_q.comm_lost;
  assign bypass_timing = (s_q.bypass_s != 13'h0000);

endmodule

/* bench/oma_arbiter_asserts.sv */
// Purpose: port assertions for the occupancy mode arbiter
// Assumes: cfg is static, one clock domain
// Notes: manual and sensor checks allow comm_lost, which masks the network
`timescale 1ns/10ps
module oma_arbiter_asserts (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input oma_pkg::oma_occ_req_t manual_occupancy_command_in, // manual command
  input oma_pkg::oma_occ_req_t scheduled_occupancy_in, // schedule
  input oma_pkg::oma_occ_req_t sensed_occupancy_in, // sensor
  input wire logic net_rx, // network update pulse
  input oma_pkg::oma_cfg_t cfg, // configuration
  input wire logic cool_mode, // cooling when high
  input wire logic [15:0] space_temp, // space temperature
  input oma_pkg::oma_occ_t eff_mode, // effective mode
  input wire logic [15:0] heat_sp, // heating setpoint
  input wire logic [15:0] cool_sp, // cooling setpoint
  input oma_pkg::oma_cap_t cap, // capacity
  input wire logic comm_lost // watchdog expired
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // mode follows the network one cycle later
  a_manual_occ: assert property (manual_occupancy_command_in == 3'h4
    |=> comm_lost || eff_mode == oma_pkg::OMA_OCC) else $error("manual occupied lost");
  a_manual_stby: assert property (manual_occupancy_command_in == 3'h7
    |=> comm_lost || eff_mode == oma_pkg::OMA_STBY) else $error("manual standby lost");
  a_sensor_prec: assert property (manual_occupancy_command_in[2] == 1'b0
    && scheduled_occupancy_in[2] == 1'b0 && sensed_occupancy_in == 3'h5
    |=> comm_lost || eff_mode inside {oma_pkg::OMA_UNOCC, oma_pkg::OMA_BYPASS})
    else $error("sensor value not used");
  // outputs that depend on the mode alone
  a_stby_econ: assert property (eff_mode == oma_pkg::OMA_STBY
    |-> cap.econ_pct == cfg.econ_stby_min) else $error("standby damper wrong");
  a_stby_setpt: assert property (eff_mode == oma_pkg::OMA_STBY
    |-> heat_sp == cfg.stby_heat && cool_sp == cfg.stby_cool) else $error("standby sp wrong");
  a_unocc_setpt: assert property (eff_mode == oma_pkg::OMA_UNOCC
    |-> heat_sp == cfg.unocc_heat && cool_sp == cfg.unocc_cool) else $error("unocc sp wrong");
  // unoccupied on/off control against last cycle's temperature
  a_unocc_idle: assert property (eff_mode == oma_pkg::OMA_UNOCC
    && $past(space_temp) <= cfg.unocc_cool && $past(space_temp) >= cfg.unocc_heat
    |-> cap == '0) else $error("capacity on inside deadband");
  a_unocc_cool: assert property (eff_mode == oma_pkg::OMA_UNOCC && $past(cool_mode)
    && $past(space_temp) > cfg.unocc_cool
    |-> 7'h64 == (cfg.econ_enable && cfg.econ_possible ? cap.econ_pct : cap.mech_cool_pct))
    else $error("primary cooling not full");
  a_rx_clears: assert property (net_rx |=> !comm_lost) else $error("update kept loss");
endmodule

/* bench/oma_net_model.sv */
// Purpose: network side feeding the arbiter watchdog
// Assumes: one update every four cycles is enough traffic
// Notes: silent models a broken link; no update is sent then
`timescale 1ns/10ps
module oma_net_model (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic silent, // stop all traffic
  output logic net_rx // one-cycle update pulse
);
  logic [1:0] gap_q;
  // periodic pulse, well inside the shortened loss timeout
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 2'h0;
      net_rx <= 1'b0;
    end else begin
      gap_q <= gap_q + 2'h1;
      net_rx <= !silent && gap_q == 2'h3;
    end
  end
endmodule

/* bench/tb_oma_arbiter.sv */
// Purpose: self-checking bench for the occupancy mode arbiter
// Assumes: second = 4 cycles, bypass 5 s, loss 3 s
// Notes: mode table first, then capacity, override and link loss
`timescale 1ns/10ps
module tb_oma_arbiter;
  typedef struct packed {
    logic [2:0] m;
    logic [2:0] s;
    logic [2:0] n;
    logic bi;
    oma_pkg::oma_occ_t e;
  } oma_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  oma_pkg::oma_occ_req_t man = '0, sch = '0, sen = '0;
  oma_pkg::oma_sp_req_t nsp = {1'b1, 16'h0100, 16'h0200};
  oma_pkg::oma_cfg_t cfg = '0;
  logic bi = 1'b0, on_b = 1'b0, cancel_b = 1'b0, cool = 1'b0, silent = 1'b0, net_rx;
  logic [15:0] temp = 16'h0400, hsp, csp;
  oma_pkg::oma_occ_t mode;
  oma_pkg::oma_cap_t cap;
  logic lost, timing;
  int n_fail = 0, cmp_count = 0;
  oma_row_t rows [18] = '{'{3'h4, 3'h5, 3'h5, 1'b0, oma_pkg::OMA_OCC},
    '{3'h5, 3'h4, 3'h4, 1'b0, oma_pkg::OMA_UNOCC}, '{3'h7, 3'h4, 3'h4, 1'b0, oma_pkg::OMA_STBY},
    '{3'h6, 3'h4, 3'h0, 1'b0, oma_pkg::OMA_OCC}, '{3'h6, 3'h5, 3'h0, 1'b0, oma_pkg::OMA_BYPASS},
    '{3'h6, 3'h0, 3'h4, 1'b0, oma_pkg::OMA_OCC}, '{3'h6, 3'h0, 3'h5, 1'b0, oma_pkg::OMA_BYPASS},
    '{3'h6, 3'h7, 3'h0, 1'b0, oma_pkg::OMA_BYPASS}, '{3'h0, 3'h5, 3'h0, 1'b0, oma_pkg::OMA_UNOCC},
    '{3'h0, 3'h7, 3'h0, 1'b0, oma_pkg::OMA_STBY}, '{3'h0, 3'h6, 3'h0, 1'b0, oma_pkg::OMA_BYPASS},
    '{3'h0, 3'h4, 3'h4, 1'b0, oma_pkg::OMA_OCC}, '{3'h0, 3'h4, 3'h5, 1'b0, oma_pkg::OMA_STBY},
    '{3'h0, 3'h4, 3'h0, 1'b1, oma_pkg::OMA_STBY}, '{3'h0, 3'h4, 3'h4, 1'b1, oma_pkg::OMA_OCC},
    '{3'h0, 3'h0, 3'h0, 1'b1, oma_pkg::OMA_UNOCC}, '{3'h0, 3'h0, 3'h0, 1'b0, oma_pkg::OMA_OCC},
    '{3'h0, 3'h0, 3'h5, 1'b0, oma_pkg::OMA_UNOCC}};

  oma_net_model i_oma_net_model (.ref_clk, .rst_n, .silent, .net_rx);
  oma_arbiter #(.SEC_CYC(4), .BYPASS_S(5), .COMM_LOSS_S(3)) i_oma_arbiter (.ref_clk, .rst_n,
    .manual_occupancy_command_in(man), .scheduled_occupancy_in(sch), .sensed_occupancy_in(sen),
    .net_sp_in(nsp), .net_rx, .cfg, .occ_bi_pin(bi), .override_on_pin(on_b),
    .override_cancel_pin(cancel_b), .cool_mode(cool), .space_temp(temp), .eff_mode(mode),
    .heat_sp(hsp), .cool_sp(csp), .cap, .comm_lost(lost), .bypass_timing(timing));

  // clock and a watchdog far beyond the few hundred cycles needed
  always #20 ref_clk = ~ref_clk;
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // setpoints each mode should select: the bench's configuration, or nsp for occupied and bypass
  function automatic logic [31:0] exp_sp(input oma_pkg::oma_occ_t e);
    if (e == oma_pkg::OMA_UNOCC) return {16'h0300, 16'h0500};
    if (e == oma_pkg::OMA_STBY) return {16'h0350, 16'h0480};
    return {nsp.heat, nsp.cool};
  endfunction
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // held three edges so the two sync flops and edge flop see it once
  task automatic press(input logic is_cancel);
    @(posedge ref_clk);
    if (is_cancel) cancel_b <= 1'b1;
    else on_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cancel_b <= 1'b0;
    on_b <= 1'b0;
  endtask
  task automatic cap_case(input logic c, input logic [15:0] t, input logic [16:0] e);
    @(posedge ref_clk);
    cool <= c;
    temp <= t;
    wait_cyc(2);
    chk(cap, e);
    $display("capacity case done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    cfg = {16'h0300, 16'h0500, 16'h0350, 16'h0480, 16'h0380, 16'h0450, 16'h0010, 7'h14, 7'h0A,
      5'h1F};
    wait_cyc(5);
    chk({mode, cap, lost}, 20'h0); // reset values
    @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      man <= rows[i].m;
      sch <= rows[i].s;
      sen <= rows[i].n;
      bi <= rows[i].bi;
      wait_cyc(4);
      chk(mode, rows[i].e);
      chk({hsp, csp}, exp_sp(rows[i].e));
      $display("row %0d done", i);
    end
    man <= 3'h5;
    sen <= 3'h0;
    cap_case(1'b1, 16'h0400, 17'h00000);
    cap_case(1'b1, 16'h0508, 17'h19000);
    cap_case(1'b1, 16'h0520, 17'h19004);
    cap_case(1'b0, 16'h0200, 17'h00002);
    cap_case(1'b0, 16'h0300, 17'h00000);
    cfg.econ_enable <= 1'b0;
    cfg.hydro_possible <= 1'b0;
    cap_case(1'b1, 16'h0508, 17'h00320);
    cap_case(1'b0, 16'h0200, 17'h00001);
    man <= 3'h0;
    sch <= 3'h5;
    press(1'b0);
    wait_cyc(4);
    chk({mode, timing}, {oma_pkg::OMA_BYPASS, 1'b1});
    press(1'b1);
    wait_cyc(4);
    chk({mode, timing}, {oma_pkg::OMA_UNOCC, 1'b0});
    press(1'b0);
    wait_cyc(11);
    press(1'b0);
    wait_cyc(13);
    chk(mode, oma_pkg::OMA_BYPASS);
    wait_cyc(12);
    chk({mode, timing}, {oma_pkg::OMA_UNOCC, 1'b0});
    $display("override test done");
    silent <= 1'b1;
    wait_cyc(24);
    chk({mode, lost}, {oma_pkg::OMA_OCC, 1'b1});
    silent <= 1'b0;
    wait_cyc(8);
    chk({mode, lost}, {oma_pkg::OMA_UNOCC, 1'b0});
    cfg.bi_present <= 1'b0;
    bi <= 1'b1;
    sch <= 3'h0;
    wait_cyc(5);
    chk(mode, oma_pkg::OMA_OCC);
    $display("link test done");
    give_verdict();
  end
endmodule

bind oma_arbiter oma_arbiter_asserts i_oma_arbiter_asserts (.ref_clk, .rst_n,
  .manual_occupancy_command_in, .scheduled_occupancy_in, .sensed_occupancy_in, .net_rx,
  .cfg, .cool_mode, .space_temp, .eff_mode, .heat_sp, .cool_sp, .cap, .comm_lost);
